// [rtl/stepper_defs.svh]
`ifndef STEPPER_DEFS_SVH
`define STEPPER_DEFS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CORE_CLK_HZ 25000000
`define OSC_FREQ_HZ 250000
`define STEP_DIV_LOG2 13
// hold delays in tenths of a step-clock period
`define FIRST_DELAY_X10 35
`define SECOND_DELAY_X10 95
`define REPEAT_DELAY_X10 20

// ****************************************************************
// gain
// ****************************************************************
`define GAIN_STEPS 64
`define GAIN_INDEX_MIN 6'h00
`define GAIN_INDEX_MAX 6'h3F
`define GAIN_INDEX_DEFAULT 6'h0C

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_INT_STATUS 8'h08
`define ADDR_INT_MASK 8'h0C
`define ADDR_GAIN_DB 8'h10

`define CTRL_MUTE_BIT 0
`define CTRL_VOL_RESET_BIT 1
`define CTRL_RESET 1'h0
`define INT_MASK_RESET 5'h00

`define ST_OUT_EN_BIT 8
`define ST_BIAS_EN_BIT 9
`define ST_FAULT_LSB 10
`define ST_MUTED_BIT 13

`define INT_UP_BIT 0
`define INT_DOWN_BIT 1
`define INT_LIMIT_BIT 2
`define INT_FAULT_SET_BIT 3
`define INT_FAULT_CLR_BIT 4
`define INT_WIDTH 5

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/stepper_pkg.sv]
package stepper_pkg;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_FIRST = 5'h02,
      ST_SECOND = 5'h04,
      ST_REPEAT = 5'h08,
      ST_BLOCK = 5'h10
   } step_state_t;

   typedef struct packed {
      logic thermal;
      logic short_out;
      logic low_supply;
   } fault_t;

   typedef struct packed {
      logic raise;
      logic lower;
      logic vol_reset;
      logic mute;
      logic power_on;
   } pins_t;

   typedef enum logic [2:0] {
      SEL_CTRL = 3'h0,
      SEL_STATUS = 3'h1,
      SEL_INT_STATUS = 3'h2,
      SEL_INT_MASK = 3'h3,
      SEL_GAIN_DB = 3'h4,
      SEL_NONE = 3'h7
   } reg_sel_t;

endpackage : stepper_pkg

// [rtl/gain_step_mem.sv]
`timescale 1ns/1ps

// gain of each step in tenths of a dB, read data registered
module gain_step_mem (
   input wire logic i_core_clk,
   input wire logic i_clk_en,
   input wire logic [5:0] i_index,
   output logic signed [10:0] o_gain_db
);

   localparam logic signed [10:0] TABLE [0:63] = '{
      -11'sd750, -11'sd397, -11'sd340, -11'sd282, -11'sd224, -11'sd165, -11'sd105, -11'sd80,
      -11'sd55, -11'sd29, -11'sd4, 11'sd11, 11'sd26, 11'sd36, 11'sd40, 11'sd44,
      11'sd48, 11'sd51, 11'sd55, 11'sd59, 11'sd63, 11'sd67, 11'sd71, 11'sd75,
      11'sd79, 11'sd83, 11'sd87, 11'sd91, 11'sd96, 11'sd100, 11'sd104, 11'sd107,
      11'sd112, 11'sd116, 11'sd120, 11'sd123, 11'sd127, 11'sd132, 11'sd136, 11'sd140,
      11'sd144, 11'sd148, 11'sd152, 11'sd156, 11'sd160, 11'sd164, 11'sd168, 11'sd172,
      11'sd176, 11'sd180, 11'sd184, 11'sd188, 11'sd192, 11'sd196, 11'sd200, 11'sd204,
      11'sd209, 11'sd213, 11'sd217, 11'sd221, 11'sd225, 11'sd229, 11'sd234, 11'sd238
   };

   always_ff @(posedge i_core_clk) begin
      if (i_clk_en) begin
         o_gain_db <= TABLE[i_index];
      end
   end

endmodule : gain_step_mem

// [rtl/pushbutton_volume_stepper.sv]
// Summary of operation
// - step timing from oscillator divided by 8192
// - first step after 3.5 held periods
// - second step after further 9.5 periods
// - then one step every 2 periods
// - short press gives no step
// - gain index spans 64 settings
// - power-up or volume reset loads default gain
// - unmuting keeps the stored gain index
// - both inputs high leaves gain unchanged
// - mute low disables outputs at once
// - mute defaults to off when undriven
// - power-off low kills bias and outputs
// - low supply disables outputs until recovery
// - output short disables outputs until removed
// - over-temperature disables outputs, latched until cooled
// - thermal fault clears after cooling hysteresis
// - volume reset input is active low
`timescale 1ns/1ps
`include "stepper_defs.svh"

module pushbutton_volume_stepper #(
   parameter int unsigned HALF_STEP_CYCLES = 409600
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_clk_en,
   input wire logic i_vol_raise_n,
   input wire logic i_vol_lower_n,
   input wire logic i_vol_reset_n,
   input wire logic i_mute_n,
   input wire logic i_power_off_n,
   input wire logic i_low_supply_lockout,
   input wire logic i_output_short_guard,
   input wire logic i_temp_over_trip,
   input wire logic i_temp_cooled,
   output logic o_out_enable,
   output logic o_bias_enable,
   output logic [5:0] o_gain_index,
   output logic signed [10:0] o_gain_db,
   output logic o_irq,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready
);

   // ****************************************************************
   // timing constants
   // ****************************************************************
   // the step clock is osc / 2^13; the core counts half periods of it
   localparam longint unsigned HALF_STEP_NOMINAL =
      (longint'(`CORE_CLK_HZ) * (longint'(1) << `STEP_DIV_LOG2)) / (longint'(`OSC_FREQ_HZ) * 64'd2);
   localparam logic [4:0] FIRST_HALVES = 5'((`FIRST_DELAY_X10 * 2) / 10);
   localparam logic [4:0] SECOND_HALVES = 5'((`SECOND_DELAY_X10 * 2) / 10);
   localparam logic [4:0] REPEAT_HALVES = 5'((`REPEAT_DELAY_X10 * 2) / 10);
   localparam logic [18:0] HALF_LAST = 19'(HALF_STEP_CYCLES - 1);

   function automatic stepper_pkg::reg_sel_t decode(input logic [7:0] addr);
      case (addr)
         `ADDR_CTRL: decode = stepper_pkg::SEL_CTRL;
         `ADDR_STATUS: decode = stepper_pkg::SEL_STATUS;
         `ADDR_INT_STATUS: decode = stepper_pkg::SEL_INT_STATUS;
         `ADDR_INT_MASK: decode = stepper_pkg::SEL_INT_MASK;
         `ADDR_GAIN_DB: decode = stepper_pkg::SEL_GAIN_DB;
         default: decode = stepper_pkg::SEL_NONE;
      endcase
   endfunction : decode

   // ****************************************************************
   // pins and protection
   // ****************************************************************
   stepper_pkg::pins_t pins;
   stepper_pkg::fault_t fault;
   logic thermal;
   logic fault_any_q;
   logic sw_mute;
   logic sw_vol_reset;

   assign pins.raise = ~i_vol_raise_n;
   assign pins.lower = ~i_vol_lower_n;
   assign pins.vol_reset = ~i_vol_reset_n;
   // the pad pull-up keeps the pin high when undriven; sw_mute resets to zero
   assign pins.mute = ~i_mute_n | sw_mute;
   assign pins.power_on = i_power_off_n;
   assign fault.low_supply = i_low_supply_lockout;
   assign fault.short_out = i_output_short_guard;
   assign fault.thermal = thermal;

   wire fault_any = |fault;
   wire next_out_enable = pins.power_on & ~pins.mute & ~fault_any;

   // hysteresis: the hot comparator sets, only the cool one clears
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         thermal <= 1'b0;
      end else if (i_clk_en) begin
         if (i_temp_over_trip) begin
            thermal <= 1'b1;
         end else if (i_temp_cooled) begin
            thermal <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_out_enable <= 1'b0;
         o_bias_enable <= 1'b0;
         fault_any_q <= 1'b0;
      end else if (i_clk_en) begin
         o_out_enable <= next_out_enable;
         o_bias_enable <= pins.power_on;
         fault_any_q <= fault_any;
      end
   end

   // ****************************************************************
   // step clock
   // ****************************************************************
   logic [18:0] half_cnt;
   logic [4:0] halves;
   wire half_tick = (half_cnt == HALF_LAST);

   // ****************************************************************
   // hold sequencer
   // ****************************************************************
   stepper_pkg::step_state_t state;
   stepper_pkg::step_state_t next_state;
   logic dir_up;
   logic [5:0] gain_index;

   wire one_pressed = pins.raise ^ pins.lower;
   wire both_pressed = pins.raise & pins.lower;
   wire vol_reset = pins.vol_reset | sw_vol_reset;
   wire same_dir = one_pressed & (pins.raise == dir_up);
   wire [4:0] halves_inc = halves + 5'h01;
   logic [4:0] target;
   logic step_req;

   always_comb begin
      case (state)
         stepper_pkg::ST_FIRST: target = FIRST_HALVES;
         stepper_pkg::ST_SECOND: target = SECOND_HALVES;
         default: target = REPEAT_HALVES;
      endcase
   end

   wire timed_out = half_tick & (halves_inc == target);

   always_comb begin
      next_state = state;
      step_req = 1'b0;
      case (state)
         stepper_pkg::ST_IDLE: begin
            if (both_pressed) begin
               next_state = stepper_pkg::ST_BLOCK;
            end else if (one_pressed) begin
               next_state = stepper_pkg::ST_FIRST;
            end
         end
         stepper_pkg::ST_FIRST, stepper_pkg::ST_SECOND, stepper_pkg::ST_REPEAT: begin
            if (!same_dir) begin
               // releasing ends the run: a short press stops here
               next_state = both_pressed ? stepper_pkg::ST_BLOCK : stepper_pkg::ST_IDLE;
            end else if (timed_out) begin
               step_req = 1'b1;
               next_state = (state == stepper_pkg::ST_FIRST) ? stepper_pkg::ST_SECOND
                                                             : stepper_pkg::ST_REPEAT;
            end
         end
         stepper_pkg::ST_BLOCK: begin
            if (!both_pressed) begin
               next_state = stepper_pkg::ST_IDLE;
            end
         end
         default: next_state = stepper_pkg::ST_IDLE;
      endcase
      if (vol_reset) begin
         next_state = stepper_pkg::ST_IDLE;
         step_req = 1'b0;
      end
   end

   // a new press restarts the divider so every hold is timed from its own start
   wire restart = (next_state != state) | step_req;

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         half_cnt <= 19'h00000;
         halves <= 5'h00;
      end else if (i_clk_en) begin
         if (restart || state == stepper_pkg::ST_IDLE) begin
            half_cnt <= 19'h00000;
            halves <= 5'h00;
         end else if (half_tick) begin
            half_cnt <= 19'h00000;
            halves <= halves_inc;
         end else begin
            half_cnt <= half_cnt + 19'h00001;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         state <= stepper_pkg::ST_IDLE;
         dir_up <= 1'b0;
      end else if (i_clk_en) begin
         state <= next_state;
         if (state == stepper_pkg::ST_IDLE) begin
            dir_up <= pins.raise;
         end
      end
   end

   // ****************************************************************
   // gain index
   // ****************************************************************
   wire at_max = (gain_index == `GAIN_INDEX_MAX);
   wire at_min = (gain_index == `GAIN_INDEX_MIN);
   wire at_limit = dir_up ? at_max : at_min;
   wire step_up = step_req & dir_up & ~at_max;
   wire step_down = step_req & ~dir_up & ~at_min;

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         gain_index <= `GAIN_INDEX_DEFAULT;
      end else if (i_clk_en) begin
         if (vol_reset) begin
            gain_index <= `GAIN_INDEX_DEFAULT;
         end else if (step_up) begin
            gain_index <= gain_index + 6'h01;
         end else if (step_down) begin
            gain_index <= gain_index - 6'h01;
         end
         // mute never touches the index, so unmuting resumes it
      end
   end

   assign o_gain_index = gain_index;

   gain_step_mem u_gain_mem (
      .i_core_clk(i_core_clk),
      .i_clk_en(i_clk_en),
      .i_index(gain_index),
      .o_gain_db(o_gain_db)
   );

   // ****************************************************************
   // events and interrupt
   // ****************************************************************
   logic [`INT_WIDTH-1:0] int_status;
   logic [`INT_WIDTH-1:0] int_mask;
   logic [`INT_WIDTH-1:0] int_clear;
   wire [`INT_WIDTH-1:0] events = {fault_any_q & ~fault_any, fault_any & ~fault_any_q,
                                   step_req & at_limit, step_down, step_up};

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         int_status <= '0;
         o_irq <= 1'b0;
      end else if (i_clk_en) begin
         // set wins over a clear in the same cycle
         int_status <= (int_status & ~int_clear) | events;
         o_irq <= |(int_status & int_mask);
      end
   end

   // ****************************************************************
   // axi4-lite slave
   // ****************************************************************
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic w_lane0;

   assign o_s_axi_awready = ~aw_held & ~o_s_axi_bvalid & i_clk_en;
   assign o_s_axi_wready = ~w_held & ~o_s_axi_bvalid & i_clk_en;
   assign o_s_axi_arready = ~o_s_axi_rvalid & i_clk_en;

   wire do_write = aw_held & w_held & ~o_s_axi_bvalid;
   wire stepper_pkg::reg_sel_t wsel = decode(aw_addr);
   wire stepper_pkg::reg_sel_t rsel = decode(i_s_axi_araddr);
   wire wr_en = do_write & w_lane0;

   assign int_clear = (wr_en && wsel == stepper_pkg::SEL_INT_STATUS) ? w_data[`INT_WIDTH-1:0] : '0;

   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h00000000;
      case (rsel)
         stepper_pkg::SEL_CTRL: rd_mux[`CTRL_MUTE_BIT] = sw_mute;
         stepper_pkg::SEL_STATUS: begin
            rd_mux[5:0] = gain_index;
            rd_mux[`ST_OUT_EN_BIT] = o_out_enable;
            rd_mux[`ST_BIAS_EN_BIT] = o_bias_enable;
            rd_mux[`ST_FAULT_LSB +: 3] = fault;
            rd_mux[`ST_MUTED_BIT] = pins.mute;
         end
         stepper_pkg::SEL_INT_STATUS: rd_mux[`INT_WIDTH-1:0] = int_status;
         stepper_pkg::SEL_INT_MASK: rd_mux[`INT_WIDTH-1:0] = int_mask;
         stepper_pkg::SEL_GAIN_DB: rd_mux = 32'(o_gain_db);
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_lane0 <= 1'b0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= `RESP_OKAY;
      end else if (i_clk_en) begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_s_axi_awaddr;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= i_s_axi_wdata;
            w_lane0 <= i_s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= (wsel == stepper_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
         end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h00000000;
         o_s_axi_rresp <= `RESP_OKAY;
      end else if (i_clk_en) begin
         if (i_s_axi_arvalid && o_s_axi_arready) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= rd_mux;
            o_s_axi_rresp <= (rsel == stepper_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
         end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
         end
      end
   end

   // control and mask registers
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         sw_mute <= `CTRL_RESET;
         sw_vol_reset <= 1'b0;
         int_mask <= `INT_MASK_RESET;
      end else if (i_clk_en) begin
         sw_vol_reset <= wr_en && wsel == stepper_pkg::SEL_CTRL && w_data[`CTRL_VOL_RESET_BIT];
         if (wr_en && wsel == stepper_pkg::SEL_CTRL) begin
            sw_mute <= w_data[`CTRL_MUTE_BIT];
         end
         if (wr_en && wsel == stepper_pkg::SEL_INT_MASK) begin
            int_mask <= w_data[`INT_WIDTH-1:0];
         end
      end
   end

endmodule : pushbutton_volume_stepper

// [sim/stepper_props.sv]
`timescale 1ns/1ps

// ****
// output checks
// ****
module stepper_props (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_vol_raise_n,
   input wire logic i_vol_lower_n,
   input wire logic i_vol_reset_n,
   input wire logic i_mute_n,
   input wire logic i_power_off_n,
   input wire logic i_low_supply_lockout,
   input wire logic i_output_short_guard,
   input wire logic i_temp_over_trip,
   input wire logic o_out_enable,
   input wire logic o_bias_enable,
   input wire logic [5:0] o_gain_index,
   input wire logic o_s_axi_bvalid
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   wire logic quiet = i_vol_raise_n && i_vol_lower_n;

   // 12 is left out: a volume reset may jump there from anywhere
   gain_step_a: assert property (!$past(i_srst) && $changed(o_gain_index) && o_gain_index != 6'h0C
      |-> ({1'b0, o_gain_index} - {1'b0, $past(o_gain_index)}) inside {7'h01, 7'h7F})
      else $error("gain moved by more than one step");
   hold_still_a: assert property ($past(quiet) && $past(i_vol_reset_n) && !$past(i_srst)
      && !$past(o_s_axi_bvalid) |-> $stable(o_gain_index)) else $error("gain moved with no button");
   vol_reset_a: assert property (!i_vol_reset_n |=> o_gain_index == 6'h0C)
      else $error("reset did not load default gain");
   mute_off_a: assert property (!i_mute_n |=> !o_out_enable) else $error("outputs on while muted");
   power_off_a: assert property (!i_power_off_n |=> !o_bias_enable && !o_out_enable)
      else $error("bias on while powered off");
   supply_off_a: assert property (i_low_supply_lockout |=> !o_out_enable)
      else $error("outputs on at low supply");
   short_off_a: assert property (i_output_short_guard |=> !o_out_enable)
      else $error("outputs on during short");
   thermal_off_a: assert property (i_temp_over_trip |-> ##2 !o_out_enable)
      else $error("outputs on while hot");

   cover property (o_gain_index == 6'h3F);
   cover property (o_gain_index == 6'h00);
   cover property ($rose(o_out_enable));
endmodule : stepper_props

bind pushbutton_volume_stepper stepper_props u_props (.i_core_clk(i_core_clk), .i_srst(i_srst),
   .i_vol_raise_n(i_vol_raise_n), .i_vol_lower_n(i_vol_lower_n), .i_vol_reset_n(i_vol_reset_n),
   .i_mute_n(i_mute_n), .i_power_off_n(i_power_off_n), .i_low_supply_lockout(i_low_supply_lockout),
   .i_output_short_guard(i_output_short_guard), .i_temp_over_trip(i_temp_over_trip),
   .o_out_enable(o_out_enable), .o_bias_enable(o_bias_enable), .o_gain_index(o_gain_index),
   .o_s_axi_bvalid(o_s_axi_bvalid));

// [sim/button_pins.sv]
`timescale 1ns/1ps

// ****
// buttons and control pins
// ****
module button_pins (
   input wire logic i_raise,
   input wire logic i_lower,
   input wire logic i_reset,
   input wire logic i_mute,
   input wire logic i_run,
   output logic o_vol_raise_n,
   output logic o_vol_lower_n,
   output logic o_vol_reset_n,
   output logic o_mute_n,
   output logic o_power_off_n
);
   assign o_vol_raise_n = !i_raise;
   assign o_vol_lower_n = !i_lower;
   assign o_vol_reset_n = !i_reset;
   // an undriven mute line floats high on its pull-up
   assign o_mute_n = !i_mute;
   // pull-down: a floating line means powered off
   assign o_power_off_n = i_run;
endmodule : button_pins

// [sim/pushbutton_volume_stepper_bench.sv]
`timescale 1ns/1ps
`include "stepper_defs.svh"

module pushbutton_volume_stepper_bench;
   localparam int H = 4;
   logic clk = 0, srst = 1, raise = 0, lower = 0, vres = 0, mute = 0, run = 1;
   logic low = 0, shrt = 0, hot = 0, cool = 0, awvalid = 0, wvalid = 0, arvalid = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic raise_n, lower_n, vres_n, mute_n, off_n, out_en, bias_en, irq;
   logic awready, wready, bvalid, arready, rvalid;
   logic [5:0] idx;
   logic signed [10:0] db;
   logic [1:0] bresp, rresp;
   int miscompares = 0, samples_checked = 0;

   always #20 clk = ~clk;

   button_pins u_pins (.i_raise(raise), .i_lower(lower), .i_reset(vres), .i_mute(mute), .i_run(run),
      .o_vol_raise_n(raise_n), .o_vol_lower_n(lower_n), .o_vol_reset_n(vres_n), .o_mute_n(mute_n),
      .o_power_off_n(off_n));
   pushbutton_volume_stepper #(.HALF_STEP_CYCLES(H)) dut (.i_core_clk(clk), .i_srst(srst),
      .i_clk_en(1'b1), .i_vol_raise_n(raise_n), .i_vol_lower_n(lower_n), .i_vol_reset_n(vres_n),
      .i_mute_n(mute_n), .i_power_off_n(off_n), .i_low_supply_lockout(low), .i_output_short_guard(shrt),
      .i_temp_over_trip(hot), .i_temp_cooled(cool), .o_out_enable(out_en), .o_bias_enable(bias_en),
      .o_gain_index(idx), .o_gain_db(db), .o_irq(irq), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(1'b1));

   // ****
   // helpers
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic ad, wd;
      ad = 0;
      wd = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (!ad && awready) begin
            ad = 1;
            awvalid <= 0;
         end
         if (!wd && wready) begin
            wd = 1;
            wvalid <= 0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      chk(bresp, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic [1:0] e);
      araddr <= a;
      arvalid <= 1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge clk); while (rvalid !== 1'b1);
      chk(rdata & m, x);
      chk(rresp, e);
   endtask : rd

   // press one button for n cycles, then let the index settle
   task automatic hold(input logic up, input int n);
      raise <= up;
      lower <= !up;
      tick(n);
      raise <= 0;
      lower <= 0;
      tick(4);
   endtask : hold

   // hold lengths are kept mid-segment, so an edge of slack either way is harmless
   function automatic int nsteps(input int n);
      if (n <= 7 * H) return 0;
      if (n <= 26 * H) return 1;
      return 2 + (n - 26 * H - 1) / (4 * H);
   endfunction : nsteps

   function automatic int sat(input int v);
      return v < 0 ? 0 : (v > 63 ? 63 : v);
   endfunction : sat

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   // ****
   // tests
   // ****
   initial begin
      int k, d, n, e;
      k = $urandom(47);
      tick(20);
      chk(idx, 6'h0C);
      srst <= 0;
      tick(3);
      chk(out_en, 1'b1);
      chk(db, 11'h01A);
      rd(`ADDR_STATUS, 32'h3F, 32'h0C, `RESP_OKAY);
      hold(1, 5 * H);
      chk(idx, 6'h0C);
      hold(1, 20 * H);
      chk(idx, 6'h0D);
      e = 13;
      repeat (4) begin
         k = $urandom_range(5);
         d = $urandom_range(1);
         n = 28 * H + 4 * H * k + 2;
         hold(d[0], n);
         e = sat(d ? e + nsteps(n) : e - nsteps(n));
         chk(idx, e);
      end
      hold(1, 28 * H + 4 * H * 70 + 2);
      chk(idx, 6'h3F);
      chk(irq, 1'b0);
      wr(`ADDR_INT_MASK, 32'h1 << `INT_LIMIT_BIT, `RESP_OKAY);
      tick(2);
      chk(irq, 1'b1);
      wr(`ADDR_INT_STATUS, 32'h1F, `RESP_OKAY);
      tick(2);
      chk(irq, 1'b0);
      hold(0, 28 * H + 4 * H * 70 + 2);
      chk(idx, 6'h00);
      raise <= 1;
      lower <= 1;
      tick(40 * H);
      chk(idx, 6'h00);
      lower <= 0;
      tick(20 * H);
      raise <= 0;
      tick(4);
      chk(idx, 6'h01);
      vres <= 1;
      tick(3);
      chk(idx, 6'h0C);
      vres <= 0;
      mute <= 1;
      tick(2);
      chk(out_en, 1'b0);
      mute <= 0;
      tick(2);
      chk(out_en, 1'b1);
      chk(idx, 6'h0C);
      for (int i = 0; i < 4; i++) begin
         low <= i == 0;
         shrt <= i == 1;
         hot <= i == 2;
         run <= i != 3;
         tick(3);
         chk(out_en, 1'b0);
         chk(bias_en, i != 3);
         low <= 0;
         shrt <= 0;
         hot <= 0;
         run <= 1;
         tick(3);
         chk(out_en, i != 2);
         cool <= 1;
         tick(1);
         cool <= 0;
         tick(3);
         chk(out_en, 1'b1);
      end
      hold(0, 20 * H);
      chk(idx, 6'h0B);
      wr(`ADDR_CTRL, 32'h3, `RESP_OKAY);
      tick(2);
      chk(idx, 6'h0C);
      chk(out_en, 1'b0);
      rd(`ADDR_CTRL, 32'h3, 32'h1, `RESP_OKAY);
      rd(`ADDR_GAIN_DB, 32'hFFFFFFFF, 32'h1A, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      tick(2);
      chk(out_en, 1'b1);
      k = $urandom_range(31);
      wr(`ADDR_INT_MASK, k, `RESP_OKAY);
      rd(`ADDR_INT_MASK, 32'h1F, k, `RESP_OKAY);
      rd(8'h20, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
      wr(8'h24, 32'h0, `RESP_SLVERR);
      conclude();
   end

   // about 3700 cycles are expected; 25000 leaves room
   initial begin
      #1000000;
      miscompares++;
      conclude();
   end
endmodule : pushbutton_volume_stepper_bench
